// File: pma_consts.svh
`ifndef PMA_CONSTS_SVH
`define PMA_CONSTS_SVH
`define PMA_RST_VEC   16'hFFFE
`define PMA_FLAGS_RST 8'hD0
`define PMA_F_C       0
`define PMA_F_V       1
`define PMA_F_Z       2
`define PMA_F_N       3
`define PMA_F_I       4
`define PMA_F_H       5
`define PMA_F_X       6
`define PMA_F_S       7
`define PMA_QDEPTH    4
`define PMA_QPTR_W    2
`define PMA_QCNT_W    3
`define PMA_QMIN      3'h3
`define PMA_PG0_HI    8'h00
`define PMA_STK_STEP  16'h0002
`define PMA_ONE       16'h0001
`endif

// File: pma_pkg.sv
package pma_pkg;
  typedef enum logic [2:0] {
    PMA_REG_ONLY, PMA_LITERAL, PMA_PAGE_ZERO, PMA_FULL_ADDR, PMA_RELATIVE, PMA_INDEXED
  } pma_mode_e;
  typedef enum logic [2:0] {
    PMA_SEL_A, PMA_SEL_B, PMA_SEL_D, PMA_SEL_X, PMA_SEL_Y, PMA_SEL_STK, PMA_SEL_PC, PMA_SEL_FLAGS
  } pma_sel_e;
  typedef enum logic [3:0] {
    PMA_ST_VEC_HI, PMA_ST_VEC_LO, PMA_ST_IDLE, PMA_ST_POST, PMA_ST_OPND, PMA_ST_CALC,
    PMA_ST_IND_HI, PMA_ST_IND_LO, PMA_ST_PUSH_HI, PMA_ST_PUSH_LO
  } pma_state_e;
  typedef struct packed {
    pma_mode_e   mode;
    logic        wide;
    logic [3:0]  cond;
  } pma_ins_s;
  typedef struct packed {
    logic        en;
    pma_sel_e    sel;
    logic [15:0] data;
  } pma_wr_s;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] stk;
    logic [15:0] pc;
    logic [7:0]  flags;
  } pma_regs_s;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pma_mem_s;
endpackage

// File: pma_queue.sv
`timescale 1ns/1ns
`default_nettype none
`include "pma_consts.svh"
module pma_queue
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   flush_in,
  input  wire logic                   push_in,
  input  wire logic [7:0]             push_byte_in,
  input  wire logic                   pop_in,
  output logic      [7:0]             head_out,
  output logic      [`PMA_QCNT_W-1:0] count_out
);
  logic [7:0]             mem [`PMA_QDEPTH];
  logic [`PMA_QPTR_W-1:0] wr_ptr;
  logic [`PMA_QPTR_W-1:0] rd_ptr;
  logic                   do_pop;
  logic                   do_push;

  assign do_pop   = pop_in && (count_out != '0);
  assign do_push  = push_in && (count_out != `PMA_QCNT_W'(`PMA_QDEPTH));
  assign head_out = mem[rd_ptr];

  always_ff @(posedge clk_sys_in)
  begin
    if (do_push && !flush_in)
    begin
      mem[wr_ptr] <= push_byte_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count_out <= '0;
    end
    else if (flush_in)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count_out <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count_out <= count_out + `PMA_QCNT_W'(do_push) - `PMA_QCNT_W'(do_pop);
    end
  end
endmodule
`default_nettype wire

// File: pma_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "pma_consts.svh"
module pma_core
  import pma_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        ins_start_in,
  input  wire pma_ins_s    ins_in,
  input  wire logic        push_in,
  input  wire logic [15:0] push_data_in,
  input  wire pma_wr_s     reg_wr_in,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        mem_ack_in,
  output var  pma_mem_s    mem_out,
  output var  pma_regs_s   regs_out,
  output logic      [15:0] ea_out,
  output logic      [15:0] opnd_out,
  output logic      [7:0]  opcode_out,
  output logic      [7:0]  peek_out,
  output logic             done_out,
  output logic             taken_out,
  output logic             ready_out
);
  pma_state_e              state;
  pma_ins_s                ins;
  pma_regs_s               regs;
  pma_mem_s                mem;
  logic [7:0]              post;
  logic [7:0]              ptr_hi;
  logic [1:0]              need;
  logic [1:0]              rr;
  logic                    own;
  logic                    pf_drop;
  logic [15:0]             fetch_addr;
  logic [7:0]              q_head;
  logic [`PMA_QCNT_W-1:0]  q_count;
  logic                    q_pop;
  logic                    pf_push;
  logic                    own_ack;
  logic                    start_ok;
  logic                    wr_ok;
  logic                    branch;
  logic                    flush;
  logic [15:0]             flush_val;
  logic                    fsm_mem;
  logic [15:0]             fsm_addr;
  logic                    is_auto;
  logic                    is_ind;
  logic [15:0]             base;
  logic [15:0]             auto_amt;
  logic [15:0]             idx_ea;
  logic [15:0]             rel_target;
  logic [15:0]             next_ea;
  logic                    cond_ok;
  logic [1:0]              start_need;

  assign regs_out = regs;
  assign mem_out  = mem;

  // ************************************************************
  // instruction queue
  // ************************************************************
  pma_queue u_queue
  (
    .clk_sys_in   (clk_sys_in),
    .rst_b_in     (rst_b_in),
    .flush_in     (flush),
    .push_in      (pf_push),
    .push_byte_in (mem_rdata_in),
    .pop_in       (q_pop),
    .head_out     (q_head),
    .count_out    (q_count)
  );

  // ************************************************************
  // decode and address arithmetic
  // ************************************************************
  function automatic logic [1:0] tail_bytes(input logic [7:0] pb);
    if (!pb[5] || pb[7:5] != 3'b111 || pb[2])
    begin
      tail_bytes = 2'h0;
    end
    else
    begin
      tail_bytes = pb[1] ? 2'h2 : 2'h1;
    end
  endfunction

  assign start_ok = (state == PMA_ST_IDLE) && ready_out && ins_start_in;
  assign wr_ok    = reg_wr_in.en && (state == PMA_ST_IDLE) && !ins_start_in && !push_in;
  assign own_ack  = mem.req && own && mem_ack_in;
  assign q_pop    = start_ok || (((state == PMA_ST_POST) || (state == PMA_ST_OPND))
                    && (q_count != '0));
  assign pf_push  = mem.req && !own && mem_ack_in && !pf_drop && !flush;
  assign rr       = (post[7:5] == 3'b111) ? post[4:3] : post[7:6];
  assign is_auto  = post[5] && (post[7:5] != 3'b111);
  assign is_ind   = (post[7:5] == 3'b111) && (post[1:0] == 2'b11);
  assign auto_amt = post[3] ? {12'hFFF, post[3:0]} : {12'h000, post[3:0]} + `PMA_ONE;
  assign branch   = (state == PMA_ST_CALC) && (ins.mode == PMA_RELATIVE) && cond_ok;
  assign fsm_mem  = (state == PMA_ST_VEC_HI) || (state == PMA_ST_VEC_LO)
                    || (state == PMA_ST_IND_HI) || (state == PMA_ST_IND_LO)
                    || (state == PMA_ST_PUSH_HI) || (state == PMA_ST_PUSH_LO);

  always_comb
  begin
    case (rr)
      2'h0:    base = regs.x;
      2'h1:    base = regs.y;
      2'h2:    base = regs.stk;
      default: base = regs.pc;
    endcase
  end

  always_comb
  begin
    if (!post[5])
    begin
      idx_ea = base + {{11{post[4]}}, post[4:0]};
    end
    else if (is_auto)
    begin
      idx_ea = post[4] ? base : base + auto_amt;
    end
    else if (!post[2])
    begin
      idx_ea = post[1] ? base + opnd_out
                       : base + {{8{post[0]}}, opnd_out[7:0]};
    end
    else
    begin
      case (post[1:0])
        2'h0:    idx_ea = base + {8'h00, regs.a};
        2'h1:    idx_ea = base + {8'h00, regs.b};
        default: idx_ea = base + {regs.a, regs.b};
      endcase
    end
  end

  // offset is in the low byte unless the instruction says 16 bits
  assign rel_target = regs.pc + (ins.wide ? opnd_out : {{8{opnd_out[7]}}, opnd_out[7:0]});

  always_comb
  begin
    case (ins.cond)
      4'h0:    cond_ok = 1'b1;
      4'h2:    cond_ok = !regs.flags[`PMA_F_Z];
      4'h3:    cond_ok = regs.flags[`PMA_F_Z];
      4'h4:    cond_ok = !regs.flags[`PMA_F_C];
      4'h5:    cond_ok = regs.flags[`PMA_F_C];
      4'h6:    cond_ok = !regs.flags[`PMA_F_N];
      4'h7:    cond_ok = regs.flags[`PMA_F_N];
      4'h8:    cond_ok = !regs.flags[`PMA_F_V];
      4'h9:    cond_ok = regs.flags[`PMA_F_V];
      4'hA:    cond_ok = regs.flags[`PMA_F_N] == regs.flags[`PMA_F_V];
      4'hB:    cond_ok = regs.flags[`PMA_F_N] != regs.flags[`PMA_F_V];
      default: cond_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    case (ins.mode)
      PMA_PAGE_ZERO: next_ea = {`PMA_PG0_HI, opnd_out[7:0]};
      PMA_FULL_ADDR: next_ea = opnd_out;
      PMA_RELATIVE:  next_ea = rel_target;
      PMA_INDEXED:   next_ea = idx_ea;
      default:       next_ea = regs.pc;
    endcase
    case (ins_in.mode)
      PMA_LITERAL, PMA_RELATIVE: start_need = ins_in.wide ? 2'h2 : 2'h1;
      PMA_FULL_ADDR:             start_need = 2'h2;
      default:                   start_need = 2'h1;
    endcase
    case (state)
      PMA_ST_VEC_HI:  fsm_addr = `PMA_RST_VEC;
      PMA_ST_VEC_LO:  fsm_addr = `PMA_RST_VEC + `PMA_ONE;
      PMA_ST_IND_HI:  fsm_addr = ea_out;
      PMA_ST_IND_LO:  fsm_addr = ea_out + `PMA_ONE;
      PMA_ST_PUSH_HI: fsm_addr = regs.stk - `PMA_STK_STEP;
      default:        fsm_addr = regs.stk - `PMA_ONE;
    endcase
    if (state == PMA_ST_VEC_LO)
    begin
      flush_val = {ptr_hi, mem_rdata_in};
    end
    else if (branch)
    begin
      flush_val = rel_target;
    end
    else
    begin
      flush_val = reg_wr_in.data;
    end
  end

  assign flush = (state == PMA_ST_VEC_LO && own_ack) || branch
                 || (wr_ok && reg_wr_in.sel == PMA_SEL_PC);

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state      <= PMA_ST_VEC_HI;
      ins        <= '0;
      post       <= 8'h00;
      ptr_hi     <= 8'h00;
      need       <= 2'h0;
      opnd_out   <= 16'h0000;
      opcode_out <= 8'h00;
      ea_out     <= 16'h0000;
      done_out   <= 1'b0;
      taken_out  <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (state)
        PMA_ST_VEC_HI, PMA_ST_IND_HI:
          if (own_ack)
          begin
            ptr_hi <= mem_rdata_in;
            state  <= (state == PMA_ST_VEC_HI) ? PMA_ST_VEC_LO : PMA_ST_IND_LO;
          end
        PMA_ST_VEC_LO:
          if (own_ack)
          begin
            state <= PMA_ST_IDLE;
          end
        PMA_ST_IDLE:
          if (start_ok)
          begin
            ins        <= ins_in;
            opcode_out <= q_head;
            opnd_out   <= 16'h0000;
            taken_out  <= 1'b0;
            need       <= start_need;
            if (ins_in.mode == PMA_REG_ONLY)
            begin
              done_out <= 1'b1;
            end
            else
            begin
              state <= (ins_in.mode == PMA_INDEXED) ? PMA_ST_POST : PMA_ST_OPND;
            end
          end
          else if (push_in)
          begin
            opnd_out <= push_data_in;
            state    <= PMA_ST_PUSH_HI;
          end
        PMA_ST_POST:
          if (q_count != '0)
          begin
            post  <= q_head;
            need  <= tail_bytes(q_head);
            state <= (tail_bytes(q_head) == 2'h0) ? PMA_ST_CALC : PMA_ST_OPND;
          end
        PMA_ST_OPND:
          if (q_count != '0)
          begin
            opnd_out <= {opnd_out[7:0], q_head};
            need     <= need - 2'h1;
            if (need == 2'h1)
            begin
              state <= PMA_ST_CALC;
            end
          end
        PMA_ST_CALC:
        begin
          ea_out    <= next_ea;
          taken_out <= branch;
          if (ins.mode == PMA_INDEXED && is_ind)
          begin
            state <= PMA_ST_IND_HI;
          end
          else
          begin
            done_out <= 1'b1;
            state    <= PMA_ST_IDLE;
          end
        end
        PMA_ST_IND_LO:
          if (own_ack)
          begin
            ea_out   <= {ptr_hi, mem_rdata_in};
            done_out <= 1'b1;
            state    <= PMA_ST_IDLE;
          end
        PMA_ST_PUSH_HI:
          if (own_ack)
          begin
            state <= PMA_ST_PUSH_LO;
          end
        PMA_ST_PUSH_LO:
          if (own_ack)
          begin
            done_out <= 1'b1;
            state    <= PMA_ST_IDLE;
          end
        default: state <= PMA_ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // programmer's registers
  // ************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      regs     <= '0;
      regs.flags <= `PMA_FLAGS_RST;
    end
    else
    begin
      if (flush)
      begin
        regs.pc <= flush_val;
      end
      else if (q_pop)
      begin
        regs.pc <= regs.pc + `PMA_ONE;
      end
      if (wr_ok)
      begin
        case (reg_wr_in.sel)
          PMA_SEL_A:   regs.a <= reg_wr_in.data[7:0];
          PMA_SEL_B:   regs.b <= reg_wr_in.data[7:0];
          PMA_SEL_D:   {regs.a, regs.b} <= reg_wr_in.data;
          PMA_SEL_X:   regs.x <= reg_wr_in.data;
          PMA_SEL_Y:   regs.y <= reg_wr_in.data;
          PMA_SEL_STK:   regs.stk <= reg_wr_in.data;
          PMA_SEL_FLAGS: regs.flags <= reg_wr_in.data[7:0];
          default:     regs.pc <= regs.pc;
        endcase
      end
      if (state == PMA_ST_CALC && ins.mode == PMA_INDEXED && is_auto)
      begin
        case (rr)
          2'h0:    regs.x <= base + auto_amt;
          2'h1:    regs.y <= base + auto_amt;
          default: regs.stk <= base + auto_amt;
        endcase
      end
      if (state == PMA_ST_PUSH_LO && own_ack)
      begin
        regs.stk <= regs.stk - `PMA_STK_STEP;
      end
    end
  end

  // ************************************************************
  // memory port and prefetch
  // ************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mem        <= '0;
      own        <= 1'b0;
      pf_drop    <= 1'b0;
      fetch_addr <= 16'h0000;
    end
    else
    begin
      if (flush)
      begin
        fetch_addr <= flush_val;
      end
      else if (pf_push)
      begin
        fetch_addr <= fetch_addr + `PMA_ONE;
      end
      if (mem.req)
      begin
        if (mem_ack_in)
        begin
          mem.req <= 1'b0;
          mem.we  <= 1'b0;
          pf_drop <= 1'b0;
        end
        else if (flush && !own)
        begin
          pf_drop <= 1'b1;
        end
      end
      else if (fsm_mem)
      begin
        mem.req   <= 1'b1;
        own       <= 1'b1;
        mem.we    <= (state == PMA_ST_PUSH_HI) || (state == PMA_ST_PUSH_LO);
        mem.addr  <= fsm_addr;
        mem.wdata <= (state == PMA_ST_PUSH_HI) ? opnd_out[15:8] : opnd_out[7:0];
      end
      else if (!flush && q_count != `PMA_QCNT_W'(`PMA_QDEPTH))
      begin
        mem.req  <= 1'b1;
        own      <= 1'b0;
        mem.we   <= 1'b0;
        mem.addr <= fetch_addr;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ready_out <= 1'b0;
      peek_out  <= 8'h00;
    end
    else
    begin
      ready_out <= (state == PMA_ST_IDLE) && (q_count >= `PMA_QMIN) && !flush
                   && !start_ok && !push_in;
      peek_out  <= q_head;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  a_reset_masks: assert property (!$past(rst_b_in) |->
    regs.flags[`PMA_F_S] && regs.flags[`PMA_F_X] && regs.flags[`PMA_F_I])
    else $error("mask bits not set after reset");
  a_reset_vector: assert property (!$past(rst_b_in) |->
    ##[0:2] (mem.req && mem.addr == `PMA_RST_VEC))
    else $error("reset vector not fetched");
  a_ready_queue: assert property (ready_out |-> q_count >= `PMA_QMIN)
    else $error("ready with fewer than three bytes");
  a_pop_advance: assert property (q_pop && !flush |=> regs.pc == $past(regs.pc) + `PMA_ONE)
    else $error("pc did not follow consumed byte");
  a_page_zero: assert property (done_out && ins.mode == PMA_PAGE_ZERO
    && state == PMA_ST_IDLE |-> ea_out[15:8] == `PMA_PG0_HI)
    else $error("page zero upper byte not zero");
  a_auto_post: assert property (state == PMA_ST_CALC && ins.mode == PMA_INDEXED
    && is_auto && post[4] && rr == 2'h0 |=> ea_out == $past(regs.x)
    && regs.x == $past(regs.x) + $past(auto_amt))
    else $error("post step wrong");
  a_auto_no_pc: assert property (state == PMA_ST_CALC && ins.mode == PMA_INDEXED
    && is_auto |-> rr != 2'h3)
    else $error("pc used in auto mode");
  a_push_order: assert property (state == PMA_ST_PUSH_HI && mem.req && own |->
    mem.we && mem.addr == regs.stk - `PMA_STK_STEP && mem.wdata == opnd_out[15:8])
    else $error("push high byte misplaced");
  a_push_sp: assert property (state == PMA_ST_PUSH_LO && own_ack |=>
    regs.stk == $past(regs.stk) - `PMA_STK_STEP ##1 done_out == 1'b0)
    else $error("stack pointer not lowered by two");
  a_ind_ptr: assert property (state == PMA_ST_IND_LO && own_ack |=>
    ea_out == {$past(ptr_hi), $past(mem_rdata_in)} && done_out)
    else $error("indirect pointer wrong");
  a_rel_branch: assert property (branch |=> regs.pc == $past(rel_target) && taken_out)
    else $error("branch target wrong");
  a_double_acc: assert property (wr_ok && reg_wr_in.sel == PMA_SEL_D |=>
    regs.a == $past(reg_wr_in.data[15:8]) && regs.b == $past(reg_wr_in.data[7:0]))
    else $error("double accumulator halves swapped");

  c_indirect: cover property (state == PMA_ST_IND_LO && own_ack);
  c_branch: cover property (branch);
  c_push: cover property (state == PMA_ST_PUSH_LO && own_ack);
endmodule
`default_nettype wire

// File: pma_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************
// memory partner
// ************************
module pma_mem_model
  import pma_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire pma_mem_s   mem_in,
  input  wire logic [1:0] wait_in,
  output logic            ack_out,
  output logic [7:0]      rdata_out
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt = 2'h0;
  initial ack_out = 1'b0;
  initial rdata_out = 8'h00;
  // data line toggles when no answer
  always @(posedge clk_sys_in)
  begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (mem_in.req && !ack_out)
    begin
      cnt <= cnt + 2'h1;
      if (cnt >= wait_in)
      begin
        cnt <= 2'h0;
        ack_out <= 1'b1;
        if (mem_in.we)
          mem[mem_in.addr] <= mem_in.wdata;
        else
          rdata_out <= mem[mem_in.addr];
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pma_pkg::*;
  logic clk_sys_in, rst_b_in, ins_start_in, push_in, ack, done_out, taken_out, ready_out;
  logic [15:0] push_data_in, ea_out, opnd_out;
  logic [7:0]  rdata;
  logic [1:0]  slow;
  pma_ins_s    ins_in;
  pma_wr_s     reg_wr_in;
  pma_mem_s    mem_out;
  pma_regs_s   regs_out;
  int          fails, checked, cycles;
  logic [7:0]  prog [32] = '{8'h01, 8'h12, 8'h34, 8'h02, 8'h56, 8'h03, 8'h1F, 8'h04, 8'hE2,
    8'hFF, 8'hFF, 8'h05, 8'hE6, 8'h06, 8'h30, 8'h07, 8'hCF, 8'h08, 8'hBE, 8'hEF,
    8'h09, 8'h02, 8'h00, 8'h00, 8'h0A, 8'hE3, 8'h00, 8'h10, 8'h0B, 8'hE7, 8'h0C, 8'h05};
  pma_core dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ins_start_in(ins_start_in),
    .ins_in(ins_in), .push_in(push_in), .push_data_in(push_data_in), .reg_wr_in(reg_wr_in),
    .mem_rdata_in(rdata), .mem_ack_in(ack), .mem_out(mem_out), .regs_out(regs_out),
    .ea_out(ea_out), .opnd_out(opnd_out), .opcode_out(), .peek_out(), .done_out(done_out),
    .taken_out(taken_out), .ready_out(ready_out));
  pma_mem_model mem_model (.clk_sys_in(clk_sys_in), .mem_in(mem_out), .wait_in(slow),
    .ack_out(ack), .rdata_out(rdata));
  // ************************
  // helpers
  // ************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic await(input bit rdy);
    repeat (80)
    begin
      @(negedge clk_sys_in);
      if ((rdy ? ready_out : done_out) === 1'b1)
        return;
    end
    fails++;
    summarize();
  endtask
  task automatic run(input pma_mode_e m, input logic w, input logic [15:0] ea,
    input logic [3:0] c = 4'h0);
    await(1);
    @(posedge clk_sys_in);
    ins_start_in <= 1'b1;
    ins_in <= '{m, w, c};
    @(posedge clk_sys_in);
    ins_start_in <= 1'b0;
    await(0);
    check(ea_out, ea);
  endtask
  task automatic regw(input pma_sel_e s, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= '{1'b1, s, d};
    @(posedge clk_sys_in);
    reg_wr_in.en <= 1'b0;
  endtask
  // ************************
  // scenarios
  // ************************
  task automatic t_reset();
    check({8'h00, regs_out.flags}, 16'h00D0);
    @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check(mem_out.addr, 16'hFFFE);
    await(1);
    check(regs_out.pc, 16'h1000);
  endtask
  task automatic t_direct();
    slow <= 2'h0;
    run(PMA_FULL_ADDR, 1'b0, 16'h1234);
    run(PMA_PAGE_ZERO, 1'b0, 16'h0056);
  endtask
  task automatic t_index();
    regw(PMA_SEL_X, 16'h0005);
    run(PMA_INDEXED, 1'b0, 16'h0004);
    run(PMA_INDEXED, 1'b0, 16'h0004);
    regw(PMA_SEL_D, 16'h8001);
    @(negedge clk_sys_in);
    check({8'h00, regs_out.a}, 16'h0080);
    run(PMA_INDEXED, 1'b0, 16'h8006);
    run(PMA_INDEXED, 1'b0, 16'h0005);
    @(negedge clk_sys_in);
    check(regs_out.x, 16'h0006);
    run(PMA_INDEXED, 1'b0, 16'h1020);
  endtask
  task automatic t_flow();
    run(PMA_LITERAL, 1'b1, 16'h1014);
    check(opnd_out, 16'hBEEF);
    run(PMA_RELATIVE, 1'b0, 16'h1018);
    check({15'h0, taken_out}, 16'h0001);
  endtask
  task automatic t_ind();
    run(PMA_INDEXED, 1'b0, 16'h1234);
    run(PMA_INDEXED, 1'b0, 16'h5678);
    run(PMA_RELATIVE, 1'b0, 16'h1025, 4'h1);
    check({15'h0, taken_out}, 16'h0000);
    check(regs_out.pc, 16'h1020);
  endtask
  task automatic t_push();
    slow <= 2'h2;
    regw(PMA_SEL_STK, 16'h2000);
    @(posedge clk_sys_in);
    push_in <= 1'b1;
    push_data_in <= 16'hABCD;
    @(posedge clk_sys_in);
    push_in <= 1'b0;
    await(0);
    check({mem_model.mem[16'h1FFE], mem_model.mem[16'h1FFF]}, 16'hABCD);
    @(negedge clk_sys_in);
    check(regs_out.stk, 16'h1FFE);
  endtask
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // hang guard
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    rst_b_in = 1'b0;
    ins_start_in = 1'b0;
    ins_in = '{PMA_REG_ONLY, 1'b0, 4'h0};
    push_in = 1'b0;
    push_data_in = 16'h0000;
    reg_wr_in = '{1'b0, PMA_SEL_A, 16'h0000};
    slow = 2'h1;
    foreach (prog[i])
      mem_model.mem[16'h1000 + i] = prog[i];
    mem_model.mem[16'hFFFE] = 8'h10;
    mem_model.mem[16'hFFFF] = 8'h00;
    mem_model.mem[16'h0016] = 8'h12;
    mem_model.mem[16'h0017] = 8'h34;
    mem_model.mem[16'h8007] = 8'h56;
    mem_model.mem[16'h8008] = 8'h78;
    repeat (4) @(posedge clk_sys_in);
    t_reset();
    t_direct();
    t_index();
    t_flow();
    t_ind();
    t_push();
    summarize();
  end
endmodule
`default_nettype wire
